// File: include/gcu_pkg.sv
package gcu_pkg;
	// register pointers
	localparam logic [7:0] GCU_REG_DIR     = 8'h03;
	localparam logic [7:0] GCU_REG_DEFAULT = 8'h09;
	localparam logic [7:0] GCU_REG_LEVEL   = 8'h0f;
	localparam logic [7:0] GCU_REG_MASK    = 8'h11;
	localparam logic [7:0] GCU_REG_FLAGS   = 8'h13;
	// reset values
	localparam logic [7:0] GCU_DIR_RST     = 8'h00;
	localparam logic [7:0] GCU_DEFAULT_RST = 8'h00;
	localparam logic [7:0] GCU_MASK_RST    = 8'h00;
	localparam logic [7:0] GCU_PTR_RST     = 8'h00;
	// bus clock and data rest high, synchroniser starts there
	localparam logic [1:0] GCU_BUS_IDLE    = 2'b11;
	// bus address, upper seven bits of the address byte
	localparam logic [6:0] GCU_DEV_ADDR    = 7'h43;
	// bit count of one byte on the bus
	localparam logic [3:0] GCU_BYTE_BITS   = 4'h8;
	// number of port pins
	localparam int         GCU_PINS        = 8;

	// software-visible configuration
	typedef struct packed {
		logic [7:0] dir;     // 1 = pin is an output
		logic [7:0] dflt;    // idle level per input
		logic [7:0] mask;    // 1 = keep pin off the request line
	} gcu_cfg_t;

	// bus transaction states
	typedef enum logic [3:0] {
		GCU_ST_IDLE = 4'h0,
		GCU_ST_ADDR = 4'h1,
		GCU_ST_AACK = 4'h2,
		GCU_ST_PTR  = 4'h3,
		GCU_ST_PACK = 4'h4,
		GCU_ST_WDAT = 4'h5,
		GCU_ST_WACK = 4'h6,
		GCU_ST_RDAT = 4'h7,
		GCU_ST_RACK = 4'h8,
		GCU_ST_SKIP = 4'h9
	} gcu_state_t;
endpackage

// File: hw/gcu_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for a group of outside levels
module gcu_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         srst,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;   // read only by the second stage
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync_out;

	// a group narrower than one bit has nothing to carry
	if (W < 1) begin : g_bad_width
		$error("sync width must be at least one");
	end

	// next values
	always_comb begin
		next_stage1   = async_in;
		next_sync_out = stage1;
	end

	// registers
	always_ff @(posedge clock) begin
		if (srst) begin
			// idle level, so no false edge follows reset
			stage1   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule // gcu_sync

// File: hw/gcu_top.sv
`timescale 1ns/1ns
// Overview of operation
// - request line is open-drain, driven low only
// - change sets status bit, pulls request low
// - status bit holds until status register read
// - no new event until pin returns default
// - level register shows present input pin levels
// - request stays low until host services it
// - detection runs on core clock, not bus clock
// - one register per read, no auto-increment
// - read without pointer uses stored pointer
// - answers address byte 86h write, 87h read
// - event only when level opposes default bit
// - mask blocks request line, status still sets
// - output pins never flag nor request
module gcu_top
	import gcu_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = GCU_DEV_ADDR
) (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                srst,
	// bus pins, data line split into in, out and enable
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	// port pins as seen by the input buffers
	input  wire logic [GCU_PINS-1:0] pin_in,
	// open-drain request line
	output logic                     int_n_out,
	output logic                     int_n_oe,
	// configuration for the port drivers
	output logic [GCU_PINS-1:0]      pin_dir
);
	// synchronised outside levels
	logic [GCU_PINS+1:0] sync_lvl;
	logic                scl_s;          // bus clock, synchronised
	logic                sda_s;          // bus data, synchronised
	logic [GCU_PINS-1:0] pin_s;          // pins, synchronised
	logic                scl_d;          // previous bus clock
	logic                sda_d;          // previous bus data
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;

	// bus engine state
	gcu_state_t          state;
	gcu_state_t          next_state;
	logic [3:0]          bits;           // bits seen in this byte
	logic [3:0]          next_bits;
	logic [7:0]          shift;          // incoming byte
	logic [7:0]          next_shift;
	logic [7:0]          rbyte;          // outgoing byte
	logic [7:0]          next_rbyte;
	logic                rw;             // 1 = read transfer
	logic                next_rw;
	logic [7:0]          ptr;            // stored register pointer
	logic [7:0]          next_ptr;
	logic                next_sda_oe;
	gcu_cfg_t            cfg;
	gcu_cfg_t            next_cfg;
	logic [7:0]          clr;            // status bits taken by a read

	// change detection state
	logic [7:0]          flags;          // latched change events
	logic [7:0]          next_flags;
	logic [7:0]          armed;          // pin may raise a new event
	logic [7:0]          next_armed;
	logic                next_int_oe;
	logic [7:0]          is_input;
	logic [7:0]          off_dflt;
	logic [7:0]          level;

	// register read decode
	function automatic logic [7:0] reg_read(input logic [7:0] p, input gcu_cfg_t c,
		input logic [7:0] lv, input logic [7:0] fl);
		case (p)
			GCU_REG_DIR:     reg_read = c.dir;
			GCU_REG_DEFAULT: reg_read = c.dflt;
			GCU_REG_MASK:    reg_read = c.mask;
			GCU_REG_LEVEL:   reg_read = lv;
			GCU_REG_FLAGS:   reg_read = fl;
			default:         reg_read = 8'h00;
		endcase
	endfunction

	// all outside levels pass two flops
	gcu_sync #(
		.W      (GCU_PINS + 2),
		.RST_VAL({GCU_BUS_IDLE, {GCU_PINS{1'b0}}})
	) u_sync (
		.clock   (clock),
		.srst    (srst),
		.async_in({scl_in, sda_in, pin_in}),
		.sync_out(sync_lvl)
	);

	assign scl_s     = sync_lvl[GCU_PINS+1];
	assign sda_s     = sync_lvl[GCU_PINS];
	assign pin_s     = sync_lvl[GCU_PINS-1:0];
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	// start and stop are data edges while the clock is high
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	assign is_input  = ~cfg.dir;
	// mismatch against the default, inputs only
	assign off_dflt  = (pin_s ^ cfg.dflt) & is_input;
	// outputs read low in the level register
	assign level     = pin_s & is_input;

	// bus engine: next values
	always_comb begin
		next_state  = state;
		next_bits   = bits;
		next_shift  = shift;
		next_rbyte  = rbyte;
		next_rw     = rw;
		next_ptr    = ptr;
		next_sda_oe = sda_oe;
		next_cfg    = cfg;
		clr         = 8'h00;
		if (bus_start) begin
			// also a repeated start; pointer kept
			next_state  = GCU_ST_ADDR;
			next_bits   = 4'h0;
			next_sda_oe = 1'b0;
		end else if (bus_stop) begin
			next_state  = GCU_ST_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			// sample on the rising clock
			case (state)
				GCU_ST_ADDR, GCU_ST_PTR, GCU_ST_WDAT: begin
					next_shift = {shift[6:0], sda_s};
					next_bits  = bits + 4'h1;
				end
				GCU_ST_RDAT: next_bits = bits + 4'h1;
				GCU_ST_RACK: next_state = GCU_ST_SKIP;
				default: ;
			endcase
		end else if (scl_fall) begin
			// drive on the falling clock so data is stable while high
			case (state)
				GCU_ST_ADDR: begin
					if (bits == GCU_BYTE_BITS) begin
						if (shift[7:1] == DEV_ADDR) begin
							next_state  = GCU_ST_AACK;
							next_rw     = shift[0];
							next_sda_oe = 1'b1;
						end else begin
							next_state = GCU_ST_SKIP;
						end
					end
				end
				GCU_ST_AACK: begin
					next_bits = 4'h0;
					if (rw) begin
						// stored pointer serves a bare read
						next_rbyte  = reg_read(ptr, cfg, level, flags);
						next_sda_oe = ~next_rbyte[7];
						next_state  = GCU_ST_RDAT;
						if (ptr == GCU_REG_FLAGS) begin
							clr = flags;
						end
					end else begin
						next_sda_oe = 1'b0;
						next_state  = GCU_ST_PTR;
					end
				end
				GCU_ST_PTR: begin
					if (bits == GCU_BYTE_BITS) begin
						next_ptr    = shift;
						next_sda_oe = 1'b1;
						next_state  = GCU_ST_PACK;
					end
				end
				GCU_ST_WDAT: begin
					if (bits == GCU_BYTE_BITS) begin
						case (ptr)
							GCU_REG_DIR:     next_cfg.dir  = shift;
							GCU_REG_DEFAULT: next_cfg.dflt = shift;
							GCU_REG_MASK:    next_cfg.mask = shift;
							default: ;
						endcase
						next_sda_oe = 1'b1;
						next_state  = GCU_ST_WACK;
					end
				end
				GCU_ST_PACK, GCU_ST_WACK: begin
					// pointer never moves on, later bytes hit the same register
					next_sda_oe = 1'b0;
					next_bits   = 4'h0;
					next_state  = GCU_ST_WDAT;
				end
				GCU_ST_RDAT: begin
					if (bits == GCU_BYTE_BITS) begin
						next_sda_oe = 1'b0;
						next_state  = GCU_ST_RACK;
					end else begin
						next_rbyte  = {rbyte[6:0], 1'b0};
						next_sda_oe = ~rbyte[6];
					end
				end
				default: ;
			endcase
		end
	end

	// bus engine: registers
	always_ff @(posedge clock) begin
		if (srst) begin
			state  <= GCU_ST_IDLE;
			bits   <= 4'h0;
			shift  <= 8'h00;
			rbyte  <= 8'h00;
			rw     <= 1'b0;
			ptr    <= GCU_PTR_RST;
			sda_oe <= 1'b0;
			cfg    <= '{dir: GCU_DIR_RST, dflt: GCU_DEFAULT_RST, mask: GCU_MASK_RST};
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			state  <= next_state;
			bits   <= next_bits;
			shift  <= next_shift;
			rbyte  <= next_rbyte;
			rw     <= next_rw;
			ptr    <= next_ptr;
			sda_oe <= next_sda_oe;
			cfg    <= next_cfg;
			scl_d  <= scl_s;
			sda_d  <= sda_s;
		end
	end

	// change detection: next values, core clock only
	always_comb begin
		// re-arm once the pin is back at its default level
		next_armed  = ~off_dflt | (armed & off_dflt & ~flags);
		// a new event wins over a clear in the same cycle
		next_flags  = ((flags & ~clr) | (off_dflt & armed)) & is_input;
		// masked bits still latch but stay off the line
		next_int_oe = |(next_flags & ~cfg.mask);
	end

	// change detection: registers
	always_ff @(posedge clock) begin
		if (srst) begin
			flags     <= 8'h00;
			armed     <= 8'hff;
			int_n_oe  <= 1'b0;
			int_n_out <= 1'b0;
			sda_out   <= 1'b0;
			pin_dir   <= 8'h00;
		end else begin
			flags     <= next_flags;
			armed     <= next_armed;
			int_n_oe  <= next_int_oe;
			int_n_out <= 1'b0;
			sda_out   <= 1'b0;
			pin_dir   <= next_cfg.dir;
		end
	end
endmodule // gcu_top

// File: verification/gcu_sva.sv
`timescale 1ns/1ns
// port checker for the change unit
module gcu_sva
	import gcu_pkg::*;
(
	// clock and reset
	input wire logic       clock,
	input wire logic       srst,
	// bus, port and request pins
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [7:0] pin_in,
	input wire logic       int_n_out,
	input wire logic       int_n_oe,
	input wire logic [7:0] pin_dir
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic [3:0] quiet; // cycles without pin or bus motion, saturating
	always_ff @(posedge clock)
		if (srst || !$stable({pin_in, scl_in, sda_in})) quiet <= 4'h0;
		else if (quiet != 4'hf) quiet <= quiet + 4'h1;
	// request up while the bus clock idles high, so no read can end
	sequence s_held;
		(int_n_oe && scl_in)[*8];
	endsequence
	a_drive_low: assert property (!int_n_out && !sda_out) else $error("drive not low");
	a_reset_idle: assert property ($fell(srst) |-> pin_dir == 8'h00 && !int_n_oe && !sda_oe) else $error("busy");
	a_int_holds: assert property (s_held |=> int_n_oe) else $error("request dropped");
	a_no_spurious: assert property ($rose(int_n_oe) |-> quiet < 4'h8) else $error("request without cause");
	a_clear_low: assert property ($fell(int_n_oe) |-> !scl_in) else $error("cleared off a read");
	a_ack_rise: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2)) else $error("late drive");
	a_ack_fall: assert property ($fell(sda_oe) |-> !scl_in) else $error("release in high phase");
	a_dir_low: assert property ($changed(pin_dir) |-> !scl_in) else $error("direction off edge");
endmodule // gcu_sva
bind gcu_top gcu_sva chk_u (.clock(clock), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .pin_in(pin_in), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .pin_dir(pin_dir));

// File: verification/gcu_host.sv
`timescale 1ns/1ns
// host bus master, 160 ns bus clock, stands high between frames
module gcu_host
	import gcu_pkg::*;
(
	// resolved data line
	input  wire logic sda,
	// master drive, a one releases the line
	output logic      scl,
	output logic      sda_h
);
	initial {scl, sda_h} = 2'b11;
	// data moves in the low phase, sampled in the high phase
	task automatic bit_x(input logic b, output logic r);
		#30 sda_h = b;
		#50 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
	endtask
	// waits out the device releasing its ack first
	task automatic start_c();
		sda_h = 1'b1;
		#60 scl = 1'b1;
		#60 sda_h = 1'b0;
		#60 scl = 1'b0;
	endtask
	task automatic stop_c();
		#30 sda_h = 1'b0;
		#50 scl = 1'b1;
		#60 sda_h = 1'b1;
		#60;
	endtask
	// msb first, then the answer bit
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(v[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
		bit_x(last, r);
	endtask
	task automatic reg_wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
		logic a, b, c;
		start_c();
		put({GCU_DEV_ADDR, 1'b0}, a);
		put(p, b);
		put(v, c);
		stop_c();
		ok = a && b && c;
	endtask
	// optional pointer; a burst acks the first byte and asks for more
	task automatic reg_rd(input logic wp, input logic [7:0] p, input logic burst, output logic [7:0] v,
		output logic [7:0] v2, output logic ok);
		logic a, b, c;
		a = 1'b1;
		b = 1'b1;
		start_c();
		if (wp) begin
			put({GCU_DEV_ADDR, 1'b0}, a);
			put(p, b);
			start_c();
		end
		put({GCU_DEV_ADDR, 1'b1}, c);
		get(!burst, v);
		if (burst) get(1'b1, v2);
		stop_c();
		ok = a && b && c;
	endtask
endmodule // gcu_host

// File: verification/gcu_top_tb.sv
`timescale 1ns/1ns
// self-checking bench for the change unit
module gcu_top_tb
	import gcu_pkg::*;
;
	logic       clock = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] pin_in = 8'h00;
	logic       scl, sda_h, sda_out, sda_oe, int_n_out, int_n_oe, ok;
	logic [7:0] pin_dir, d, d2;
	int         failures = 0;
	int         total_checks = 0;
	wire        sda = sda_h && !sda_oe; // pulled up, either side pulls low
	always #5 clock = ~clock;
	gcu_top dut_u (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.pin_in(pin_in), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .pin_dir(pin_dir));
	gcu_host host_u (.sda(sda), .scl(scl), .sda_h(sda_h));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait for the request line
	task automatic wait_int(input logic w);
		int n;
		n = 0;
		while (int_n_oe !== w && n < 20) begin
			@(negedge clock);
			n++;
		end
		check({7'h0, int_n_oe}, {7'h0, w});
		if (n == 20) end_of_test();
	endtask
	// the line must read the given level after a 40-cycle quiet spell
	task automatic hold_int(input logic w);
		repeat (40) @(negedge clock);
		check({7'h0, int_n_oe}, {7'h0, w});
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		host_u.reg_wr(p, v, ok);
		check({7'h0, ok}, 8'h01);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] exp);
		host_u.reg_rd(1'b1, p, 1'b0, d, d2, ok);
		check({7'h0, ok}, 8'h01);
		check(d, exp);
	endtask
	// change with the bus idle, then service; no re-flag till back at default
	task automatic t_event();
		@(negedge clock) pin_in = 8'ha5;
		wait_int(1'b1);
		hold_int(1'b1);
		rd(GCU_REG_LEVEL, 8'ha5);
		rd(GCU_REG_FLAGS, 8'ha5);
		wait_int(1'b0);
		hold_int(1'b0);
		rd(GCU_REG_FLAGS, 8'h00);
		@(negedge clock) pin_in = 8'h00;
		hold_int(1'b0);
		@(negedge clock) pin_in = 8'h01;
		wait_int(1'b1);
		rd(GCU_REG_FLAGS, 8'h01);
	endtask
	task automatic t_mask();
		wr(GCU_REG_MASK, 8'h02);
		@(negedge clock) pin_in = 8'h03;
		hold_int(1'b0);
		rd(GCU_REG_FLAGS, 8'h02);
		wr(GCU_REG_MASK, 8'h00);
	endtask
	// a pin defaulting high flags when it falls
	task automatic t_default();
		wr(GCU_REG_DEFAULT, 8'h03);
		@(negedge clock) pin_in = 8'h02;
		wait_int(1'b1);
		rd(GCU_REG_FLAGS, 8'h01);
	endtask
	task automatic t_output();
		wr(GCU_REG_DIR, 8'h80);
		check(pin_dir, 8'h80);
		@(negedge clock) pin_in = 8'h82;
		hold_int(1'b0);
		rd(GCU_REG_FLAGS, 8'h00);
		rd(GCU_REG_LEVEL, 8'h02);
	endtask
	// stored pointer, refused burst, foreign address
	task automatic t_bus();
		host_u.reg_rd(1'b0, 8'h00, 1'b0, d, d2, ok);
		check({7'h0, ok}, 8'h01);
		check(d, 8'h02);
		host_u.reg_rd(1'b1, GCU_REG_LEVEL, 1'b1, d, d2, ok);
		check({7'h0, ok}, 8'h01);
		check(d, 8'h02);
		check(d2, 8'hff);
		host_u.start_c();
		host_u.put({~GCU_DEV_ADDR, 1'b0}, ok);
		host_u.stop_c();
		check({7'h0, ok}, 8'h00);
	endtask
	// mid-run reset: configuration back to defaults, pins off default flag again
	task automatic t_reset();
		@(negedge clock) srst = 1'b1;
		repeat (3) @(negedge clock);
		srst = 1'b0;
		repeat (5) @(negedge clock);
		check(pin_dir, 8'h00);
		wait_int(1'b1);
		rd(GCU_REG_DEFAULT, 8'h00);
		rd(GCU_REG_FLAGS, 8'h82);
	endtask
	initial begin
		repeat (20) @(negedge clock);
		srst = 1'b0;
		repeat (5) @(negedge clock);
		check(pin_dir, 8'h00);
		t_event();
		t_mask();
		t_default();
		t_output();
		t_bus();
		t_reset();
		end_of_test();
	end
endmodule // gcu_top_tb
